// ### inc/hslsi_pkg.sv
// hslsi_pkg.sv: constants and types of the strap latch and indicator.
// assumes a single 20 MHz clock and an AXI4-Lite register port.
`default_nettype none
package hslsi_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int RESET_MIN_NS = 1000;
	localparam int RESET_MIN_CYC_I =
		(RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] RESET_MIN_CYC = 5'(RESET_MIN_CYC_I);
	// ************************************************************
	// register map and bus answers
	// ************************************************************
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int CTRL_CONFIGURED_BIT = 0;
	localparam int CTRL_SUSPENDED_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// status field positions
	localparam int STS_SEL_LSB = 0;
	localparam int STS_METHOD_LSB = 3;
	localparam int STS_STRAP_EN_BIT = 5;
	localparam int STS_CODE_LSB = 6;
	localparam int STS_NONREM_LSB = 8;
	localparam int STS_LED_LOW_BIT = 12;
	localparam int STS_SELF_PWR_BIT = 13;
	localparam int STS_RATE48_BIT = 14;
	localparam int STS_IN_RESET_BIT = 15;
	// ************************************************************
	// values after reset and encodings
	// ************************************************************
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam logic [1:0] CODE_RESET = 2'h0;
	localparam logic [3:0] NONREM_RESET = 4'h0;
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_CAPTURE = 2'b01,
		ST_RUN = 2'b10
	} hslsi_state_type;
	typedef enum logic [1:0] {
		CM_DEFAULT_STRAP = 2'b00,
		CM_SMBUS = 2'b01,
		CM_EEPROM = 2'b10,
		CM_DEFAULT_FIXED = 2'b11
	} hslsi_method_type;
endpackage
`default_nettype wire

// ### logic/hslsi_sync3.sv
// hslsi_sync3.sv: three-flop pin synchroniser with agreement filter.
// assumes raw asynchronous pins; output is a clean level in clk domain.
`default_nettype none
module hslsi_sync3
	import hslsi_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// pins in, levels out
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;
	logic [WIDTH-1:0] dout_ff;
	// ************************************************************
	// per-bit chain
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			// a change only counts once stage two and three agree
			always_ff @(posedge clk) begin
				if (reset) begin
					s1_ff[i] <= 1'b0;
					s2_ff[i] <= 1'b0;
					s3_ff[i] <= 1'b0;
					dout_ff[i] <= 1'b0;
				end else if (ce) begin
					s1_ff[i] <= din[i];
					s2_ff[i] <= s1_ff[i];
					s3_ff[i] <= s2_ff[i];
					if (s2_ff[i] == s3_ff[i]) begin
						dout_ff[i] <= s3_ff[i];
					end
				end
			end
		end
	endgenerate
	assign dout = dout_ff;
endmodule // hslsi_sync3
`default_nettype wire

// ### logic/hslsi_top.sv
// hslsi_top.sv: strap capture at reset release, indicator and status.
// assumes raw board pins, a 20 MHz clock and an AXI4-Lite master.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`default_nettype none
// Operation
// - latch top select bit at reset release
// - missing top select pin reads zero
// - low reset pin resets; hold one microsecond
// - indicator on only when configured, not suspended
// - sense low means bus powered, high self
// - sample both fixed-port straps when enabled
// - code maps to none, 1, 1-2, 1-3
// - codes 00,10 active high; 01,11 active low
// - rate select low 24 MHz, high 48
// - latch lower select bits, choose method
module hslsi_top
	import hslsi_pkg::*;
#(
	parameter bit HAS_SEL2 = 1'b1
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// board pins
	input wire logic reset_pin_n,
	input wire logic config_select_bit0,
	input wire logic config_select_bit1,
	input wire logic config_select_bit2,
	input wire logic fixed_port_strap_hi,
	input wire logic ext_clock_rate_select,
	input wire logic indicator_pin_in,
	output logic activity_indicator,
	output logic activity_indicator_oe_n,
	// to the hub core
	output logic hub_reset,
	output logic [1:0] config_method,
	output logic strap_enable,
	output logic [1:0] fixed_port_code,
	output logic [3:0] nonremovable_ports,
	output logic self_powered,
	output logic ref_clk_48m,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ************************************************************
	// decoding functions
	// ************************************************************
	function automatic hslsi_method_type method_of(input logic [2:0] s);
		case (s)
			3'b000, 3'b010: method_of = CM_DEFAULT_STRAP;
			3'b001: method_of = CM_SMBUS;
			3'b011: method_of = CM_EEPROM;
			default: method_of = CM_DEFAULT_FIXED;
		endcase
	endfunction
	function automatic logic strap_of(input logic [2:0] s);
		strap_of = !s[2] && !s[0];
	endfunction
	function automatic logic [3:0] nonrem_of(input logic [1:0] c);
		case (c)
			2'b00: nonrem_of = 4'h0;
			2'b01: nonrem_of = 4'h1;
			2'b10: nonrem_of = 4'h3;
			default: nonrem_of = 4'h7;
		endcase
	endfunction
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [6:0] raw_pins;
	logic [6:0] pins;
	logic rst_stable;
	logic act_stable;
	logic strap_hi_stable;
	logic rate_stable;
	logic [2:0] sel_eff;
	assign raw_pins = {ext_clock_rate_select, fixed_port_strap_hi,
		indicator_pin_in, config_select_bit2, config_select_bit1,
		config_select_bit0, reset_pin_n};
	hslsi_sync3 #(.WIDTH(7)) u_sync (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.din(raw_pins),
		.dout(pins)
	);
	assign rst_stable = pins[0];
	assign act_stable = pins[4];
	assign strap_hi_stable = pins[5];
	assign rate_stable = pins[6];
	// absent pin in the small package reads as zero
	assign sel_eff = {HAS_SEL2 ? pins[3] : 1'b0, pins[2:1]};
	// ************************************************************
	// reset sequencing
	// ************************************************************
	hslsi_state_type st_ff;
	hslsi_state_type nxt_st;
	logic [4:0] low_cnt_ff;
	logic hub_reset_ff;
	// stretch keeps a short pin glitch from giving a runt reset
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			ST_RESET: begin
				if (rst_stable && low_cnt_ff == RESET_MIN_CYC) begin
					nxt_st = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				// a pin that drops again during capture restarts reset
				nxt_st = rst_stable ? ST_RUN : ST_RESET;
			end
			ST_RUN: begin
				if (!rst_stable) begin
					nxt_st = ST_RESET;
				end
			end
			default: nxt_st = ST_RESET;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff <= ST_RESET;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end
	// cycles spent in reset, saturating at the least pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			low_cnt_ff <= 5'h00;
		end else if (ce) begin
			if (st_ff != ST_RESET) begin
				low_cnt_ff <= 5'h00;
			end else if (low_cnt_ff != RESET_MIN_CYC) begin
				low_cnt_ff <= low_cnt_ff + 5'h01;
			end
		end
	end
	// hub core sits in reset until the straps are held
	always_ff @(posedge clk) begin
		if (reset) begin
			hub_reset_ff <= 1'b1;
		end else if (ce) begin
			hub_reset_ff <= (nxt_st != ST_RUN);
		end
	end
	// ************************************************************
	// strap capture
	// ************************************************************
	logic [2:0] cfg_sel_ff;
	hslsi_method_type method_ff;
	logic strap_en_ff;
	logic [1:0] code_ff;
	logic [3:0] nonrem_ff;
	logic led_low_ff;
	logic self_pw_ff;
	logic [1:0] code_now;
	assign code_now = strap_of(sel_eff) ?
		{strap_hi_stable, act_stable} : 2'b00;
	// loaded only in the one capture cycle, so later pin use is ignored
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_sel_ff <= SEL_RESET;
			method_ff <= CM_DEFAULT_STRAP;
			strap_en_ff <= 1'b0;
			code_ff <= CODE_RESET;
			nonrem_ff <= NONREM_RESET;
			led_low_ff <= 1'b0;
			self_pw_ff <= 1'b0;
		end else if (ce && st_ff == ST_CAPTURE) begin
			cfg_sel_ff <= sel_eff;
			method_ff <= method_of(sel_eff);
			strap_en_ff <= strap_of(sel_eff);
			code_ff <= code_now;
			nonrem_ff <= nonrem_of(code_now);
			led_low_ff <= code_now[0];
			self_pw_ff <= act_stable;
		end
	end
	// ************************************************************
	// indicator and clock rate
	// ************************************************************
	logic [1:0] ctrl_ff;
	logic active;
	logic ind_ff;
	logic ind_oe_n_ff;
	logic rate48_ff;
	assign active = ctrl_ff[CTRL_CONFIGURED_BIT] &&
		!ctrl_ff[CTRL_SUSPENDED_BIT];
	// pin released in reset so the straps can be read through it
	always_ff @(posedge clk) begin
		if (reset) begin
			ind_ff <= 1'b0;
			ind_oe_n_ff <= 1'b1;
		end else if (ce) begin
			if (st_ff == ST_RUN && nxt_st == ST_RUN) begin
				ind_oe_n_ff <= 1'b0;
				ind_ff <= active ^ led_low_ff;
			end else begin
				ind_oe_n_ff <= 1'b1;
				ind_ff <= 1'b0;
			end
		end
	end
	// rate pin is a static board strap, followed live
	always_ff @(posedge clk) begin
		if (reset) begin
			rate48_ff <= 1'b0;
		end else if (ce) begin
			rate48_ff <= rate_stable;
		end
	end
	// ************************************************************
	// axi4-lite slave
	// ************************************************************
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic aw_held_ff, w_held_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [15:0] status;
	logic do_write;
	assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	always_comb begin
		status = 16'h0000;
		status[STS_SEL_LSB +: 3] = cfg_sel_ff;
		status[STS_METHOD_LSB +: 2] = method_ff;
		status[STS_STRAP_EN_BIT] = strap_en_ff;
		status[STS_CODE_LSB +: 2] = code_ff;
		status[STS_NONREM_LSB +: 4] = nonrem_ff;
		status[STS_LED_LOW_BIT] = led_low_ff;
		status[STS_SELF_PWR_BIT] = self_pw_ff;
		status[STS_RATE48_BIT] = rate48_ff;
		status[STS_IN_RESET_BIT] = hub_reset_ff;
	end
	// address and data taken in either order, answered once both held
	always_ff @(posedge clk) begin
		if (reset) begin
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && awready_ff) begin
				awready_ff <= 1'b0;
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (!aw_held_ff && !bvalid_ff) begin
				awready_ff <= 1'b1;
			end
			if (s_axi_wvalid && wready_ff) begin
				wready_ff <= 1'b0;
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (!w_held_ff && !bvalid_ff) begin
				wready_ff <= 1'b1;
			end
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= (awaddr_ff == CTRL_OFFSET ||
					awaddr_ff == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
			end
		end
	end
	// hub state bits; status writes are accepted and dropped
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_ff <= CTRL_RESET;
		end else if (ce && do_write && awaddr_ff == CTRL_OFFSET &&
			wstrb_ff[0]) begin
			ctrl_ff <= wdata_ff[1:0];
		end
	end
	// read: data sampled at the address handshake
	always_ff @(posedge clk) begin
		if (reset) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff <= 1'b1;
				rresp_ff <= RESP_OKAY;
				if (s_axi_araddr == CTRL_OFFSET) begin
					rdata_ff <= {30'h00000000, ctrl_ff};
				end else if (s_axi_araddr == STATUS_OFFSET) begin
					rdata_ff <= {16'h0000, status};
				end else begin
					rdata_ff <= 32'h00000000;
					rresp_ff <= RESP_SLVERR;
				end
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end else if (!rvalid_ff) begin
				arready_ff <= 1'b1;
			end
		end
	end
	// ************************************************************
	// outputs
	// ************************************************************
	assign activity_indicator = ind_ff;
	assign activity_indicator_oe_n = ind_oe_n_ff;
	assign hub_reset = hub_reset_ff;
	assign config_method = method_ff;
	assign strap_enable = strap_en_ff;
	assign fixed_port_code = code_ff;
	assign nonremovable_ports = nonrem_ff;
	assign self_powered = self_pw_ff;
	assign ref_clk_48m = rate48_ff;
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	// ************************************************************
	// assertions
	// ************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_sel_top;
		(st_ff == ST_CAPTURE && ce) |=> cfg_sel_ff[2] == $past(sel_eff[2]);
	endproperty
	a_sel_top: assert property (p_sel_top)
		else $error("top select bit not latched");
	property p_sel_absent;
		st_ff == ST_RUN |-> (HAS_SEL2 || !cfg_sel_ff[2]);
	endproperty
	a_sel_absent: assert property (p_sel_absent)
		else $error("absent select bit not zero");
	property p_pin_reset;
		(ce && !rst_stable) |=> hub_reset_ff;
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("hub not in reset while pin low");
	property p_min_hold;
		(st_ff == ST_RESET && low_cnt_ff < RESET_MIN_CYC) |=> st_ff != ST_CAPTURE;
	endproperty
	a_min_hold: assert property (p_min_hold)
		else $error("reset released before least hold");
	property p_indicator;
		(ce && st_ff == ST_RUN && nxt_st == ST_RUN) |=>
			!ind_oe_n_ff && ind_ff == ($past(active) ^ led_low_ff);
	endproperty
	a_indicator: assert property (p_indicator)
		else $error("indicator level wrong");
	property p_self_power;
		(st_ff == ST_CAPTURE && ce) |=> self_pw_ff == $past(act_stable);
	endproperty
	a_self_power: assert property (p_self_power)
		else $error("self power sense not captured");
	property p_code;
		(st_ff == ST_CAPTURE && ce) |=> code_ff ==
			($past(!sel_eff[2] && !sel_eff[0]) ?
			$past({strap_hi_stable, act_stable}) : 2'b00);
	endproperty
	a_code: assert property (p_code)
		else $error("fixed port code wrong");
	property p_nonrem;
		st_ff == ST_RUN |-> nonrem_ff == {1'b0, code_ff == 2'b11,
			code_ff[1], code_ff != 2'b00};
	endproperty
	a_nonrem: assert property (p_nonrem)
		else $error("non-removable map wrong");
	property p_polarity;
		st_ff == ST_RUN |-> led_low_ff == code_ff[0];
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("indicator polarity wrong");
	property p_rate;
		ce |=> ref_clk_48m == $past(rate_stable);
	endproperty
	a_rate: assert property (p_rate)
		else $error("rate select not followed");
	property p_method;
		(st_ff == ST_CAPTURE && ce) |=> method_ff == ($past(sel_eff[2]) ?
			2'b11 : $past(sel_eff[0]) ?
			{$past(sel_eff[1]), !$past(sel_eff[1])} : 2'b00);
	endproperty
	a_method: assert property (p_method)
		else $error("config method wrong");
	property p_hold;
		(st_ff == ST_RUN ##1 st_ff == ST_RUN) |->
			$stable(code_ff) && $stable(cfg_sel_ff) && $stable(self_pw_ff);
	endproperty
	a_hold: assert property (p_hold)
		else $error("captured straps changed");
endmodule // hslsi_top
`default_nettype wire

// ### test/hslsi_board.sv
// hslsi_board.sv: board model with reset source and strap resistor.
// assumes the bench requests reset pulses and sets the strap level.
`default_nettype none
module hslsi_board
	import hslsi_pkg::*;
#(
	parameter int LOW_CYC = RESET_MIN_CYC_I
) (
	// clock and bench requests
	input wire logic clk,
	input wire logic pulse_req,
	input wire logic strap_lo,
	// device pins
	input wire logic activity_indicator,
	input wire logic activity_indicator_oe_n,
	output logic reset_pin_n,
	output logic indicator_pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************************
	// reset source and shared pin
	// ************************************************************
	logic [7:0] low_cnt_ff = 8'h00;
	// a request always runs the full low time, never cut short
	always_ff @(posedge clk) begin
		if (pulse_req) begin
			low_cnt_ff <= 8'(LOW_CYC);
		end else if (low_cnt_ff != 8'h00) begin
			low_cnt_ff <= low_cnt_ff - 8'h01;
		end
	end
	assign reset_pin_n = (low_cnt_ff == 8'h00);
	// resistor level shows only while the device lets go of the pin
	assign indicator_pin_in = activity_indicator_oe_n ? strap_lo :
		activity_indicator;
endmodule // hslsi_board
`default_nettype wire

// ### test/hslsi_top_bench.sv
// hslsi_top_bench.sv: self-checking bench of the strap latch block.
// assumes the board model and a 20 MHz clock; no other parts needed.
`default_nettype none
module hslsi_top_bench
	import hslsi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [1:0] method_small;
	logic pulse_req = 1'b0;
	logic strap_lo = 1'b0;
	logic [2:0] sel = 3'h0;
	logic fixed_port_strap_hi = 1'b0;
	logic ext_clock_rate_select = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic reset_pin_n, indicator_pin_in, activity_indicator;
	logic activity_indicator_oe_n, hub_reset, strap_enable;
	logic self_powered, ref_clk_48m, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] config_method, fixed_port_code, s_axi_bresp, s_axi_rresp;
	logic [3:0] nonremovable_ports;
	logic [31:0] s_axi_rdata;
	int num_errors = 0;
	int checks_done = 0;
	// clock edges every half period
	always #25 clk = ~clk;
	hslsi_top u_dut (.clk, .reset, .ce, .reset_pin_n,
		.config_select_bit0(sel[0]), .config_select_bit1(sel[1]),
		.config_select_bit2(sel[2]), .fixed_port_strap_hi,
		.ext_clock_rate_select, .indicator_pin_in, .activity_indicator,
		.activity_indicator_oe_n, .hub_reset, .config_method, .strap_enable,
		.fixed_port_code, .nonremovable_ports, .self_powered, .ref_clk_48m,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	// small package variant: top select pin absent, bus left idle
	hslsi_top #(.HAS_SEL2(1'b0)) u_dut_small (.clk, .reset, .ce,
		.reset_pin_n, .config_select_bit0(sel[0]),
		.config_select_bit1(sel[1]), .config_select_bit2(sel[2]),
		.fixed_port_strap_hi, .ext_clock_rate_select, .indicator_pin_in,
		.activity_indicator(), .activity_indicator_oe_n(), .hub_reset(),
		.config_method(method_small), .strap_enable(),
		.fixed_port_code(), .nonremovable_ports(), .self_powered(),
		.ref_clk_48m(), .s_axi_awaddr, .s_axi_awvalid(1'b0),
		.s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid(1'b0), .s_axi_wready(), .s_axi_bresp(),
		.s_axi_bvalid(), .s_axi_bready(1'b0), .s_axi_araddr,
		.s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_rdata(),
		.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b0));
	// slow reset source: four cycles over the minimum low time
	hslsi_board #(.LOW_CYC(24)) u_board (.clk, .pulse_req, .strap_lo,
		.activity_indicator, .activity_indicator_oe_n, .reset_pin_n,
		.indicator_pin_in);
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// handshakes judged at the falling edge, where levels have settled
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic aw, w, b;
		n = 0;
		r = 2'h3;
		// one edge apart from the last release of a previous call
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid & s_axi_bready;
			if (b) r = s_axi_bresp;
			@(posedge clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
			n++;
		end while (b !== 1'b1 && n < 40);
		if (b !== 1'b1) chk("write answer", 1, 0);
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ar, rd;
		n = 0;
		r = 2'h3;
		d = 32'h0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk);
			ar = s_axi_arvalid & s_axi_arready;
			rd = s_axi_rvalid & s_axi_rready;
			if (rd) r = s_axi_rresp;
			if (rd) d = s_axi_rdata;
			@(posedge clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (rd) s_axi_rready <= 1'b0;
			n++;
		end while (rd !== 1'b1 && n < 40);
		if (rd !== 1'b1) chk("read answer", 1, 0);
	endtask
	task automatic wait_run();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (hub_reset !== 1'b0 && n < 80);
		@(posedge clk);
		chk("hub_reset", 0, hub_reset);
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic bus_misc();
		logic [31:0] d, d0;
		logic [1:0] r;
		bus_rd(CTRL_OFFSET, d, r);
		chk("ctrl after reset", 32'(CTRL_RESET), d);
		bus_rd(STATUS_OFFSET, d0, r);
		bus_rd(8'h08, d, r);
		chk("unmapped read resp", RESP_SLVERR, r);
		chk("unmapped read data", 0, d);
		bus_wr(8'h10, 32'h3, r);
		chk("unmapped write resp", RESP_SLVERR, r);
		bus_wr(STATUS_OFFSET, 32'hFFFFFFFF, r);
		chk("status write resp", RESP_OKAY, r);
		bus_rd(STATUS_OFFSET, d, r);
		chk("status read only", d0, d);
	endtask
	task automatic rate_case();
		// enable low: the pin change must not get through
		ce <= 1'b0;
		ext_clock_rate_select <= 1'b1;
		repeat (8) @(posedge clk);
		chk("rate frozen", 0, ref_clk_48m);
		ce <= 1'b1;
		repeat (8) @(posedge clk);
		chk("rate 48", 1, ref_clk_48m);
		ext_clock_rate_select <= 1'b0;
		repeat (8) @(posedge clk);
		chk("rate 24", 0, ref_clk_48m);
	endtask
	task automatic capture_case(input logic [2:0] s, input logic [1:0] k);
		logic [1:0] m, m2, c, r;
		logic [3:0] nr;
		logic [31:0] d, st;
		m2 = (s[1:0] == 2'h1) ? 2'h1 : (s[1:0] == 2'h3) ? 2'h2 : 2'h0;
		m = s[2] ? 2'h3 : m2;
		c = (m == 2'h0) ? k : 2'h0;
		nr = (4'h1 << c) - 4'h1;
		st = {16'h0, 2'b00, k[0], c[0], nr, c, m == 2'h0, m, s};
		sel <= s;
		fixed_port_strap_hi <= k[1];
		strap_lo <= k[0];
		pulse_req <= 1'b1;
		@(posedge clk);
		pulse_req <= 1'b0;
		repeat (8) @(posedge clk);
		chk("hub_reset held", 1, hub_reset);
		wait_run();
		chk("method", m, config_method);
		chk("method small", m2, method_small);
		chk("strap_enable", m == 2'h0, strap_enable);
		chk("code", c, fixed_port_code);
		chk("nonremovable", nr, nonremovable_ports);
		chk("self powered", k[0], self_powered);
		// straps move after capture and must not be seen
		sel <= ~s;
		fixed_port_strap_hi <= ~k[1];
		strap_lo <= ~k[0];
		bus_rd(STATUS_OFFSET, d, r);
		chk("status", st, d);
		for (int cf = 0; cf < 4; cf++) begin
			bus_wr(CTRL_OFFSET, 32'(cf), r);
			repeat (3) @(posedge clk);
			chk("indicator", (cf == 1) ^ c[0], activity_indicator);
			chk("indicator drive", 0, activity_indicator_oe_n);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// watchdog: about ten times the expected run
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		wait_run();
		bus_misc();
		rate_case();
		for (int s = 0; s < 8; s++) begin
			for (int k = 0; k < 4; k++) begin
				capture_case(3'(s), 2'(k));
			end
		end
		end_of_test();
	end
endmodule // hslsi_top_bench
`default_nettype wire
